// ### rtl/etl_pkg.sv
// constants, code tables and the shared symbol encoder for the line codec
package etl_pkg;

    // lane counts and buffer depth
    localparam int          ENCODER_LANES_DEFAULT = 4;
    localparam int          DECODER_LANES_DEFAULT = 4;
    localparam int          FIFO_DEPTH_DEFAULT    = 16;

    // widths of a byte and a code group
    localparam int          BYTE_W = 8;
    localparam int          CODE_W = 10;

    // running disparity after reset: negative
    localparam logic        RD_RESET = 1'b0;

    // 5b/6b codes abcdei for negative running disparity, a in bit 5
    localparam logic [5:0]  CODE6_NEG [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};

    // 3b/4b codes fghj for negative running disparity, f in bit 3
    localparam logic [3:0]  CODE4_NEG [8] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    // special sub-blocks
    localparam logic [5:0]  K28_CODE6_NEG = 6'h0f;
    localparam logic [3:0]  ALT7_CODE4_NEG = 4'h7;
    localparam logic [4:0]  X_K28 = 5'd28;
    localparam logic [4:0]  X_D7  = 5'd7;
    localparam logic [2:0]  Y_7   = 3'd7;
    localparam logic [2:0]  Y_3   = 3'd3;

    // the twelve control bytes
    localparam int          K_COUNT = 12;
    localparam logic [7:0]  K_BYTES [12] = '{
        8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc,
        8'hf7, 8'hfb, 8'hfd, 8'hfe};

    // encodes one byte: returns {kerr, rd_out, abcdeifghj}
    function automatic logic [11:0] etl_encode(input logic [7:0] b,
                                               input logic       k,
                                               input logic       rd);
        logic [4:0] x;
        logic [2:0] y;
        logic       k28;
        logic       kv;
        logic       a7;
        logic       rd6;
        logic [5:0] c6;
        logic [3:0] c4;
        x   = b[4:0];
        y   = b[7:5];
        k28 = k && (x == X_K28);
        kv  = k28 || (k && (y == Y_7) && (x == 5'd23 || x == 5'd27 ||
                                           x == 5'd29 || x == 5'd30));
        c6  = k28 ? K28_CODE6_NEG : CODE6_NEG[x];
        if (rd && (($countones(c6) != 3) || (x == X_D7))) begin
            c6 = ~c6;
        end
        rd6 = rd ^ ($countones(c6) != 3);
        a7  = (y == Y_7) && (kv || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
                                || (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        c4  = a7 ? ALT7_CODE4_NEG : CODE4_NEG[y];
        // k28 from positive disparity also flips the balanced groups other than y = 3
        if (rd6 ? (($countones(c4) != 2) || (y == Y_3))
                : (k28 && ($countones(c4) == 2) && (y != Y_3))) begin
            c4 = ~c4;
        end
        return {k && !kv, rd6 ^ ($countones(c4) != 2), c6, c4};
    endfunction : etl_encode

endpackage : etl_pkg

// ### rtl/etl_codec.sv
// line codec: multi-lane encoder with output buffer, and multi-lane decoder

// simple fifo with level output, storage in flops
module etl_fifo #(
    parameter int width = 40,
    parameter int depth = 16
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_i,
    input  wire logic [width-1:0]           in_data_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    output logic [width-1:0]                out_data_o,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [$clog2(depth+1)-1:0]      level_o
);
    localparam int AW = (depth > 1) ? $clog2(depth) : 1;

    logic [width-1:0] mem [depth];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // handshakes
    assign in_ready_o  = int'(level_o) < depth;
    assign out_valid_o = level_o != '0;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    // storage write
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            level_o <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (int'(wr_ptr) == depth - 1) ? '0 : AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (int'(rd_ptr) == depth - 1) ? '0 : AW'(rd_ptr + 1'b1);
            end
            if (push && !pop) begin
                level_o <= level_o + 1'b1;
            end else if (pop && !push) begin
                level_o <= level_o - 1'b1;
            end
        end
    end
endmodule : etl_fifo

// Operation
// - encoder tracks running disparity itself, no disparity input.
// - present running disparity shown on a one-bit output.
// - reset sets stored running disparity to negative (zero).
// - encoder and decoder outputs valid exactly one cycle after accepted input.
// - inputs captured only on edges with input valid high, else ignored.
// - control enable per lane makes the encoder emit a control symbol.
// - decoder raises lane control flag with the decoded byte.
// - control enable on an unknown control byte raises lane symbol error.
// - decoder raises lane error flag on an invalid code group.
// - disparity output high for surplus ones, low for surplus zeros.
// - twelve control symbols, code group chosen by current disparity.
module etl_codec
    import etl_pkg::*;
#(
    parameter int encoder_lane_count = etl_pkg::ENCODER_LANES_DEFAULT,
    parameter int decoder_lane_count = etl_pkg::DECODER_LANES_DEFAULT,
    parameter int fifo_depth         = etl_pkg::FIFO_DEPTH_DEFAULT
) (
    input  wire logic                                  sys_clk_i,
    input  wire logic                                  rst_i,
    input  wire logic [encoder_lane_count*8-1:0]       enc_data_i,
    input  wire logic [encoder_lane_count-1:0]         enc_k_i,
    input  wire logic                                  enc_valid_i,
    output logic                                       enc_ready_o,
    output logic [encoder_lane_count*10-1:0]           enc_code_o,
    output logic [encoder_lane_count-1:0]              enc_kerr_o,
    output logic                                       enc_rd_o,
    output logic                                       enc_valid_o,
    output logic [encoder_lane_count*10-1:0]           ser_data_o,
    output logic                                       ser_valid_o,
    input  wire logic                                  ser_ready_i,
    input  wire logic [decoder_lane_count*10-1:0]      dec_code_i,
    input  wire logic                                  dec_valid_i,
    output logic [decoder_lane_count*8-1:0]            dec_data_o,
    output logic [decoder_lane_count-1:0]              dec_k_o,
    output logic [decoder_lane_count-1:0]              dec_kerr_o,
    output logic                                       dec_valid_o
);
    import etl_pkg::*;

    localparam int LW = $clog2(fifo_depth + 1);

    logic [encoder_lane_count*10-1:0] next_enc_code;
    logic [encoder_lane_count-1:0]    next_enc_kerr;
    logic                             next_rd;
    logic [decoder_lane_count*8-1:0]  next_dec_data;
    logic [decoder_lane_count-1:0]    next_dec_k;
    logic [decoder_lane_count-1:0]    next_dec_kerr;
    logic [LW-1:0]                    fifo_level;
    logic                             enc_take;

    // room for the word now in flight plus the one accepted now
    assign enc_ready_o = (int'(fifo_level) + int'(enc_valid_o)) < fifo_depth;
    assign enc_take    = enc_valid_i && enc_ready_o;

    // lane-by-lane encode with disparity chained upward
    always_comb begin
        logic        rd;
        logic [11:0] res;
        rd            = enc_rd_o;
        res           = '0;
        next_enc_code = '0;
        next_enc_kerr = '0;
        for (int i = 0; i < encoder_lane_count; i++) begin
            res = etl_encode(enc_data_i[i*8 +: 8], enc_k_i[i], rd);
            next_enc_code[i*10 +: 10] = res[9:0];
            next_enc_kerr[i]          = res[11];
            rd                        = res[10];
        end
        next_rd = rd;
    end

    // encoder output stage and stored disparity
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            enc_code_o  <= '0;
            enc_kerr_o  <= '0;
            enc_rd_o    <= RD_RESET;
            enc_valid_o <= 1'b0;
        end else begin
            enc_valid_o <= enc_take;
            if (enc_take) begin
                enc_code_o <= next_enc_code;
                enc_kerr_o <= next_enc_kerr;
                enc_rd_o   <= next_rd;
            end
        end
    end

    // decode each lane by searching the code space
    always_comb begin
        logic        found;
        logic        is_k;
        logic [7:0]  byte_v;
        logic [11:0] e;
        found         = 1'b0;
        is_k          = 1'b0;
        byte_v        = '0;
        e             = '0;
        next_dec_data = '0;
        next_dec_k    = '0;
        next_dec_kerr = '0;
        for (int i = 0; i < decoder_lane_count; i++) begin
            found  = 1'b0;
            is_k   = 1'b0;
            byte_v = '0;
            for (int j = 0; j < 512; j++) begin
                e = etl_encode(8'(j), 1'b0, j[8]);
                if (!found && e[9:0] == dec_code_i[i*10 +: 10]) begin
                    found  = 1'b1;
                    byte_v = 8'(j);
                end
            end
            for (int j = 0; j < 2 * K_COUNT; j++) begin
                e = etl_encode(K_BYTES[j % K_COUNT], 1'b1, j >= K_COUNT);
                if (!found && e[9:0] == dec_code_i[i*10 +: 10]) begin
                    found  = 1'b1;
                    is_k   = 1'b1;
                    byte_v = K_BYTES[j % K_COUNT];
                end
            end
            next_dec_data[i*8 +: 8] = byte_v;
            next_dec_k[i]           = is_k;
            next_dec_kerr[i]        = !found;
        end
    end

    // decoder output stage
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dec_data_o  <= '0;
            dec_k_o     <= '0;
            dec_kerr_o  <= '0;
            dec_valid_o <= 1'b0;
        end else begin
            dec_valid_o <= dec_valid_i;
            if (dec_valid_i) begin
                dec_data_o <= next_dec_data;
                dec_k_o    <= next_dec_k;
                dec_kerr_o <= next_dec_kerr;
            end
        end
    end

    // buffer toward the serialiser
    etl_fifo #(
        .width (encoder_lane_count * 10),
        .depth (fifo_depth)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (enc_code_o),
        .in_valid_i  (enc_valid_o),
        .in_ready_o  (),
        .out_data_o  (ser_data_o),
        .out_valid_o (ser_valid_o),
        .out_ready_i (ser_ready_i),
        .level_o     (fifo_level)
    );
endmodule : etl_codec

// ### verif/etl_codec_asserts.sv
// concurrent checks on the codec ports
module etl_codec_asserts #(
    parameter int encoder_lane_count = 4,
    parameter int decoder_lane_count = 4
) (
    input wire logic                            sys_clk_i,
    input wire logic                            rst_i,
    input wire logic [encoder_lane_count*8-1:0] enc_data_i,
    input wire logic [encoder_lane_count-1:0]   enc_k_i,
    input wire logic                            enc_valid_i,
    input wire logic                            enc_ready_o,
    input wire logic [encoder_lane_count*10-1:0] enc_code_o,
    input wire logic                            enc_rd_o,
    input wire logic                            enc_valid_o,
    input wire logic [encoder_lane_count*10-1:0] ser_data_o,
    input wire logic                            ser_valid_o,
    input wire logic                            ser_ready_i,
    input wire logic                            dec_valid_i,
    input wire logic [decoder_lane_count*8-1:0] dec_data_o,
    input wire logic [decoder_lane_count-1:0]   dec_kerr_o,
    input wire logic                            dec_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // latency and strobe checks
    a_enc_one_cycle: assert property (enc_valid_i && enc_ready_o |=> enc_valid_o)
        else $error("encoder output valid missing");
    a_enc_no_spur: assert property (!(enc_valid_i && enc_ready_o) |=> !enc_valid_o)
        else $error("encoder output without accepted input");
    a_dec_one_cycle: assert property (dec_valid_i |=> dec_valid_o)
        else $error("decoder output valid missing");
    a_dec_no_spur: assert property (!dec_valid_i |=> !dec_valid_o)
        else $error("decoder output without input");
    // disparity and code behaviour
    a_rd_code_hold: assert property (!enc_valid_o |-> $stable(enc_rd_o) && $stable(enc_code_o))
        else $error("encoder outputs changed without a word");
    a_rd_after_reset: assert property (disable iff (1'b0) rst_i |=> !enc_rd_o && !enc_valid_o)
        else $error("disparity not cleared by reset");
    a_comma_lane0: assert property (enc_valid_i && enc_ready_o && enc_k_i[0]
        && enc_data_i[7:0] == 8'hbc |=> enc_code_o[9:0] == ($past(enc_rd_o) ? 10'h305 : 10'h0fa))
        else $error("lane 0 comma group wrong for disparity");
    a_dec_err_zero: assert property (dec_valid_o && dec_kerr_o[0] |-> dec_data_o[7:0] == 8'h00)
        else $error("decoder error lane carries data");
    a_ser_hold: assert property (ser_valid_o && !ser_ready_i |=> ser_valid_o && $stable(ser_data_o))
        else $error("buffer head changed while stalled");
endmodule : etl_codec_asserts

bind etl_codec etl_codec_asserts #(.encoder_lane_count(encoder_lane_count),
    .decoder_lane_count(decoder_lane_count)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .enc_data_i(enc_data_i), .enc_k_i(enc_k_i), .enc_valid_i(enc_valid_i),
    .enc_ready_o(enc_ready_o), .enc_code_o(enc_code_o), .enc_rd_o(enc_rd_o),
    .enc_valid_o(enc_valid_o), .ser_data_o(ser_data_o), .ser_valid_o(ser_valid_o),
    .ser_ready_i(ser_ready_i), .dec_valid_i(dec_valid_i), .dec_data_o(dec_data_o),
    .dec_kerr_o(dec_kerr_o), .dec_valid_o(dec_valid_o));

// ### verif/etl_ser_model.sv
// serialiser model: takes buffered words, may stall
module etl_ser_model #(
    parameter int width = 40
) (
    input wire logic             sys_clk_i,
    input wire logic             rst_i,
    input wire logic             stall_i,
    input wire logic [width-1:0] ser_data_i,
    input wire logic             ser_valid_i,
    output logic                 ser_ready_o,
    output int                   pop_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ready unless told to stall
    assign ser_ready_o = !stall_i;
    // count words taken
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pop_cnt <= 0;
        end else if (ser_valid_i && ser_ready_o) begin
            pop_cnt <= pop_cnt + 1;
        end
    end
endmodule : etl_ser_model

// ### verif/etl_codec_tb_top.sv
// testbench for the line codec: encoder, buffer and decoder
module etl_codec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [31:0] enc_data_i = '0;
    logic [3:0]  enc_k_i = '0;
    logic        enc_valid_i = 1'b0;
    logic        stall = 1'b0;
    logic [39:0] dec_code_i = '0;
    logic        dec_valid_i = 1'b0;
    logic        enc_ready_o, enc_rd_o, enc_valid_o, ser_valid_o, ser_ready_i, dec_valid_o;
    logic [39:0] enc_code_o, ser_data_o;
    logic [31:0] dec_data_o;
    logic [3:0]  enc_kerr_o, dec_k_o, dec_kerr_o;
    int          pop_cnt;
    int          error_cnt = 0;
    int          comparisons = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    etl_codec #(.encoder_lane_count(4), .decoder_lane_count(4), .fifo_depth(16)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .enc_data_i(enc_data_i), .enc_k_i(enc_k_i),
        .enc_valid_i(enc_valid_i), .enc_ready_o(enc_ready_o), .enc_code_o(enc_code_o),
        .enc_kerr_o(enc_kerr_o), .enc_rd_o(enc_rd_o), .enc_valid_o(enc_valid_o),
        .ser_data_o(ser_data_o), .ser_valid_o(ser_valid_o), .ser_ready_i(ser_ready_i),
        .dec_code_i(dec_code_i), .dec_valid_i(dec_valid_i), .dec_data_o(dec_data_o),
        .dec_k_o(dec_k_o), .dec_kerr_o(dec_kerr_o), .dec_valid_o(dec_valid_o));
    etl_ser_model #(.width(40)) u_ser (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
        .ser_data_i(ser_data_o), .ser_valid_i(ser_valid_o), .ser_ready_o(ser_ready_i),
        .pop_cnt(pop_cnt));
    // compare and count
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one encoder word, outputs settled on return
    task automatic enc(input logic [31:0] d, input logic [3:0] k);
        @(posedge sys_clk_i);
        enc_data_i  <= d;
        enc_k_i     <= k;
        enc_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        enc_valid_i <= 1'b0;
        #1;
    endtask : enc
    task automatic t_reset;
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        chk(enc_rd_o, 0);
        chk(ser_valid_o, 0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_kerr;
        enc(32'h00000000, 4'h4);
        chk(enc_kerr_o, 4'h4);
        $display("test kerr done");
    endtask : t_kerr
    task automatic t_ctrl;
        enc(32'hbcbcbcbc, 4'hf);
        chk(enc_valid_o, 1);
        chk(enc_code_o, {10'h305, 10'h0fa, 10'h305, 10'h0fa});
        chk(enc_rd_o, 0);
        enc(32'hf7f7f7bc, 4'hf);
        chk(enc_code_o, {10'h057, 10'h057, 10'h057, 10'h0fa});
        chk(enc_rd_o, 1);
        enc(32'hbcbcbcbc, 4'hf);
        chk(enc_code_o, {10'h0fa, 10'h305, 10'h0fa, 10'h305});
        chk(enc_rd_o, 1);
        chk(enc_kerr_o, 0);
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_gap;
        @(posedge sys_clk_i);
        enc_data_i <= 32'h12345678;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk(enc_valid_o, 0);
        chk(enc_code_o, 40'h0);
        $display("test gap done");
    endtask : t_gap
    task automatic t_dec;
        @(posedge sys_clk_i);
        dec_code_i  <= {10'h000, 10'h305, 10'h0fa, 10'h3a8};
        dec_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        dec_valid_i <= 1'b0;
        #1;
        chk(dec_valid_o, 1);
        chk(dec_data_o, 32'h00bcbcf7);
        chk(dec_k_o, 4'h7);
        chk(dec_kerr_o, 4'h8);
        // plain data groups, lane 0 carries an invalid group
        @(posedge sys_clk_i);
        dec_code_i  <= {10'h2aa, 10'h155, 10'h274, 10'h3ff};
        dec_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        dec_valid_i <= 1'b0;
        dec_code_i  <= '0;
        #1;
        chk(dec_data_o, 32'hb54a0000);
        chk(dec_k_o, 4'h0);
        chk(dec_kerr_o, 4'h1);
        // new groups without valid must be ignored
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(dec_data_o, 32'hb54a0000);
        chk(dec_valid_o, 0);
        $display("test dec done");
    endtask : t_dec
    task automatic t_fifo;
        int   n;
        int   p;
        logic r;
        n = 0;
        p = pop_cnt;
        @(posedge sys_clk_i);
        stall       <= 1'b1;
        enc_k_i     <= '0;
        enc_data_i  <= 32'hb5b5b5b5;
        enc_valid_i <= 1'b1;
        // even words balanced b5 bytes, odd words balanced 4a bytes
        for (int i = 0; i < 40; i++) begin
            #1 r = enc_ready_o;
            @(posedge sys_clk_i);
            enc_data_i <= (i % 2 == 0) ? 32'h4a4a4a4a : 32'hb5b5b5b5;
            n += int'(r);
        end
        enc_valid_i <= 1'b0;
        stall       <= 1'b0;
        #1;
        chk(40'(n), 40'd16);
        // drain in order, head compared before each pop
        for (int i = 0; i < 16; i++) begin
            chk(ser_data_o, (i % 2 == 0) ? {4{10'h2aa}} : {4{10'h155}});
            @(posedge sys_clk_i);
            #1;
        end
        chk(40'(pop_cnt - p), 40'd16);
        chk(ser_valid_o, 0);
        $display("test fifo done");
    endtask : t_fifo
    task automatic final_report;
        $display("checks %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        t_reset();
        t_kerr();
        t_ctrl();
        t_reset();
        t_gap();
        t_dec();
        t_fifo();
        final_report();
    end
    // watchdog
    initial begin
        #20000;
        error_cnt++;
        final_report();
    end
endmodule : etl_codec_tb_top
